// *** citd_pkg.sv ***
// Shared constants and types for the interrupt, trap and dispatch decoder
package citd_pkg;
	// ==========================================
	// Register map (byte addresses)
	localparam logic [7:0] CSR_OFS = 8'h00;
	localparam logic [7:0] PEND_OFS = 8'h04;
	localparam logic [7:0] ENABLE_OFS = 8'h08;
	localparam logic [7:0] CLEAR_OFS = 8'h0c;
	localparam logic [7:0] TABLE_OFS = 8'h10;
	localparam logic [7:0] RETPTR_OFS = 8'h14;
	// ==========================================
	// Reset values
	localparam logic [31:0] CSR_RST = 32'h0000_0000;
	localparam logic [31:0] TABLE_RST = 32'h0000_0000;
	localparam logic [31:0] RETPTR_RST = 32'h0000_0000;
	// ==========================================
	// Fields
	localparam int GIE_BIT = 0;
	localparam int NUM_LSB = 4;
	localparam int NUM_W = 5;
	localparam int BASE_LSB = 10;
	localparam int DISP_W = 21;
	localparam int DISP_SHIFT = 2;
	localparam int CREG_LSB = 29;
	localparam int ZBIT = 28;
	localparam int OPC_LSB = 24;
	localparam int CSEL_W = 3;
	localparam logic [2:0] DELAY_SLOTS = 3'd5;
	// ==========================================
	// Control register selectors of the move instruction
	localparam logic [2:0] CSEL_CSR = 3'd0;
	localparam logic [2:0] CSEL_TABLE = 3'd1;
	localparam logic [2:0] CSEL_CLEAR = 3'd2;
	localparam logic [2:0] CSEL_RETPTR = 3'd3;
	localparam logic [2:0] CSEL_ENABLE = 3'd4;
	localparam logic [2:0] CSEL_PEND = 3'd5;
	// ==========================================
	// Condition register select codes
	localparam logic [2:0] CREG_NONE = 3'd0;
	localparam logic [2:0] CREG_B0 = 3'd1;
	localparam logic [2:0] CREG_B1 = 3'd2;
	localparam logic [2:0] CREG_B2 = 3'd3;
	localparam logic [2:0] CREG_A1 = 3'd4;
	localparam logic [2:0] CREG_A2 = 3'd5;
	// ==========================================
	// Opcodes
	typedef enum logic [3:0] {
		CITD_OP_NOP = 4'h0,
		CITD_OP_BR_DISP = 4'h1,
		CITD_OP_BR_REG = 4'h2,
		CITD_OP_BR_RET = 4'h3,
		CITD_OP_MV_TO_CTRL = 4'h4,
		CITD_OP_MV_FROM_CTRL = 4'h5,
		CITD_OP_LD_SHORT = 4'h6,
		CITD_OP_LD_LONG = 4'h7,
		CITD_OP_ST_SHORT = 4'h8,
		CITD_OP_ST_LONG = 4'h9
	} citd_op_t;
endpackage

// *** citd_prio_enc.sv ***
// Priority encoder picking the lowest numbered pending enabled source
`timescale 1ns/1ps
`default_nettype none
module citd_prio_enc #(
	parameter int N_SRC = 16
) (
	// Candidates
	input wire logic [N_SRC-1:0] req,
	// Result
	output logic any,
	output logic [4:0] num
);
	always_comb begin
		any = 1'b0;
		num = 5'd0;
		// Downward scan so the lowest index is left standing
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				num = 5'(i);
			end
		end
	end
endmodule
`default_nettype wire

// *** citd_dispatch.sv ***
// Interrupt polling, trap and predicated dispatch decoder with APB registers
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module citd_dispatch #(
	parameter int N_SRC = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt source pins, rising edge sets a flag
	input wire logic [N_SRC-1:0] irq_pin,
	output logic irq,
	// Instruction issue
	input wire logic insn_valid,
	input wire logic [31:0] insn_word,
	input wire logic [31:0] insn_pc,
	input wire logic [31:0] src_data,
	input wire logic [4:0] cond_nonzero,
	// Decode results
	output logic commit,
	output logic pred_illegal,
	output logic mem_load,
	output logic mem_store,
	output logic mem_unit2,
	output logic [31:0] ctrl_rdata,
	output logic branch_taken,
	output logic redirect,
	output logic [31:0] redirect_addr
);
	// ==========================================
	// Registers
	logic [31:0] csr_reg;
	logic [N_SRC-1:0] pend_reg;
	logic [N_SRC-1:0] enable_reg;
	logic [31:0] table_reg;
	logic [31:0] retptr_reg;
	logic [N_SRC-1:0] sync1_reg;
	logic [N_SRC-1:0] sync2_reg;
	logic [N_SRC-1:0] sync3_reg;
	logic [2:0] slot_reg;
	logic [31:0] target_reg;
	typedef enum logic [0:0] {CITD_IDLE, CITD_SLOTS} citd_state_t;
	citd_state_t state_reg;

	// ==========================================
	// Decode
	citd_pkg::citd_op_t op;
	logic [2:0] creg;
	logic zinv;
	logic cond_ok;
	logic cond_legal;
	logic go;
	logic [2:0] csel;
	logic [31:0] table_rd;
	logic hp_any;
	logic [4:0] hp_num;
	function automatic logic [N_SRC-1:0] fit(input logic [31:0] w);
		fit = w[N_SRC-1:0];
	endfunction
	function automatic logic [31:0] widen(input logic [N_SRC-1:0] v);
		widen = 32'h0000_0000;
		widen[N_SRC-1:0] = v;
	endfunction
	assign op = citd_pkg::citd_op_t'(insn_word[citd_pkg::OPC_LSB +: 4]);
	assign creg = insn_word[citd_pkg::CREG_LSB +: 3];
	assign zinv = insn_word[citd_pkg::ZBIT];
	assign csel = insn_word[citd_pkg::CSEL_W-1:0];
	always_comb begin
		cond_legal = 1'b1;
		cond_ok = 1'b1;
		case (creg)
			citd_pkg::CREG_NONE: cond_ok = 1'b1;
			citd_pkg::CREG_B0: cond_ok = cond_nonzero[0] ^ zinv;
			citd_pkg::CREG_B1: cond_ok = cond_nonzero[1] ^ zinv;
			citd_pkg::CREG_B2: cond_ok = cond_nonzero[2] ^ zinv;
			citd_pkg::CREG_A1: cond_ok = cond_nonzero[3] ^ zinv;
			citd_pkg::CREG_A2: cond_ok = cond_nonzero[4] ^ zinv;
			default: begin
				cond_legal = 1'b0;
				cond_ok = 1'b0;
			end
		endcase
	end
	// This term gates every decoded effect except pred_illegal and the delay slot count
	assign go = insn_valid && cond_legal && cond_ok;
	citd_prio_enc #(
		.N_SRC(N_SRC)
	) u_prio (
		.req(pend_reg & enable_reg),
		.any(hp_any),
		.num(hp_num)
	);
	always_comb begin
		table_rd = table_reg;
		table_rd[citd_pkg::BASE_LSB-1:0] = 10'h000;
		table_rd[citd_pkg::NUM_LSB +: citd_pkg::NUM_W] = hp_any ? hp_num : 5'd0;
	end

	// ==========================================
	// APB slave, zero wait states
	logic apb_wr;
	logic apb_rd;
	logic apb_hit;
	logic [31:0] apb_rdv;
	logic [31:0] wmask;
	assign pready = 1'b1;
	assign apb_wr = psel && penable && pwrite;
	// Latched in the setup cycle, so read data stands while pready is high
	assign apb_rd = psel && !penable && !pwrite;
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	always_comb begin
		apb_hit = 1'b1;
		apb_rdv = 32'h0000_0000;
		case (paddr)
			citd_pkg::CSR_OFS: apb_rdv = csr_reg;
			citd_pkg::PEND_OFS: apb_rdv = widen(pend_reg);
			citd_pkg::ENABLE_OFS: apb_rdv = widen(enable_reg);
			citd_pkg::CLEAR_OFS: apb_rdv = 32'h0000_0000;
			citd_pkg::TABLE_OFS: apb_rdv = table_rd;
			citd_pkg::RETPTR_OFS: apb_rdv = retptr_reg;
			default: apb_hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !apb_hit;
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (apb_rd) begin
			prdata <= apb_rdv;
		end
	end

	// ==========================================
	// Control writes from the move instruction or APB; the move wins a tie
	logic mv_wr;
	logic [31:0] ap_wdata;
	assign mv_wr = go && (op == citd_pkg::CITD_OP_MV_TO_CTRL);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction
	assign ap_wdata = pwdata;
	always_ff @(posedge clk) begin
		if (srst) begin
			csr_reg <= citd_pkg::CSR_RST;
		end else if (mv_wr && csel == citd_pkg::CSEL_CSR) begin
			// Whole word stored, so software and-masking keeps the other bits
			csr_reg <= src_data;
		end else if (apb_wr && paddr == citd_pkg::CSR_OFS) begin
			csr_reg <= merge(csr_reg, ap_wdata, wmask);
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			enable_reg <= '0;
		end else if (mv_wr && csel == citd_pkg::CSEL_ENABLE) begin
			enable_reg <= fit(src_data);
		end else if (apb_wr && paddr == citd_pkg::ENABLE_OFS) begin
			enable_reg <= fit(merge(widen(enable_reg), ap_wdata, wmask));
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			table_reg <= citd_pkg::TABLE_RST;
		end else if (mv_wr && csel == citd_pkg::CSEL_TABLE) begin
			table_reg <= src_data;
		end else if (apb_wr && paddr == citd_pkg::TABLE_OFS) begin
			table_reg <= merge(table_reg, ap_wdata, wmask);
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			retptr_reg <= citd_pkg::RETPTR_RST;
		end else if (mv_wr && csel == citd_pkg::CSEL_RETPTR) begin
			retptr_reg <= src_data;
		end else if (apb_wr && paddr == citd_pkg::RETPTR_OFS) begin
			retptr_reg <= merge(retptr_reg, ap_wdata, wmask);
		end
	end

	// ==========================================
	// Pending flags: pin edges set, ones written clear, set wins
	logic [N_SRC-1:0] rise;
	logic [N_SRC-1:0] clr_bits;
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= irq_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	assign rise = sync2_reg & ~sync3_reg;
	always_comb begin
		clr_bits = '0;
		if (mv_wr && (csel == citd_pkg::CSEL_CLEAR || csel == citd_pkg::CSEL_PEND)) begin
			clr_bits = fit(src_data);
		end
		if (apb_wr && (paddr == citd_pkg::CLEAR_OFS || paddr == citd_pkg::PEND_OFS)) begin
			clr_bits = clr_bits | fit(ap_wdata & wmask);
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= (pend_reg & ~clr_bits) | rise;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= csr_reg[citd_pkg::GIE_BIT] && |(pend_reg & enable_reg);
		end
	end

	// ==========================================
	// Decode outputs
	logic is_long;
	logic is_ld;
	logic is_st;
	logic [31:0] rdv;
	assign is_ld = (op == citd_pkg::CITD_OP_LD_SHORT) || (op == citd_pkg::CITD_OP_LD_LONG);
	assign is_st = (op == citd_pkg::CITD_OP_ST_SHORT) || (op == citd_pkg::CITD_OP_ST_LONG);
	assign is_long = (op == citd_pkg::CITD_OP_LD_LONG) || (op == citd_pkg::CITD_OP_ST_LONG);
	always_comb begin
		case (csel)
			citd_pkg::CSEL_CSR: rdv = csr_reg;
			citd_pkg::CSEL_TABLE: rdv = table_rd;
			citd_pkg::CSEL_RETPTR: rdv = retptr_reg;
			citd_pkg::CSEL_ENABLE: rdv = widen(enable_reg);
			citd_pkg::CSEL_PEND: rdv = widen(pend_reg);
			default: rdv = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			commit <= 1'b0;
			pred_illegal <= 1'b0;
			mem_load <= 1'b0;
			mem_store <= 1'b0;
			mem_unit2 <= 1'b0;
			ctrl_rdata <= 32'h0000_0000;
		end else begin
			commit <= go;
			pred_illegal <= insn_valid && !cond_legal;
			mem_load <= go && is_ld;
			mem_store <= go && is_st;
			// Long-offset forms exist only on the second unit
			mem_unit2 <= go && (is_ld || is_st) && (is_long || insn_word[23]);
			if (go && op == citd_pkg::CITD_OP_MV_FROM_CTRL) begin
				ctrl_rdata <= rdv;
			end
		end
	end

	// ==========================================
	// Branch and delay slots
	logic is_br;
	logic [31:0] br_target;
	logic [31:0] disp_ext;
	assign is_br = (op == citd_pkg::CITD_OP_BR_DISP) || (op == citd_pkg::CITD_OP_BR_REG)
		|| (op == citd_pkg::CITD_OP_BR_RET);
	assign disp_ext = 32'(signed'(insn_word[citd_pkg::DISP_W-1:0])) << citd_pkg::DISP_SHIFT;
	always_comb begin
		case (op)
			citd_pkg::CITD_OP_BR_DISP: br_target = insn_pc + disp_ext;
			citd_pkg::CITD_OP_BR_RET: br_target = retptr_reg;
			default: br_target = src_data;
		endcase
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= CITD_IDLE;
			slot_reg <= 3'd0;
			target_reg <= 32'h0000_0000;
			branch_taken <= 1'b0;
			redirect <= 1'b0;
			redirect_addr <= 32'h0000_0000;
		end else begin
			branch_taken <= 1'b0;
			redirect <= 1'b0;
			case (state_reg)
				CITD_IDLE: begin
					if (go && is_br) begin
						branch_taken <= 1'b1;
						target_reg <= br_target;
						slot_reg <= 3'd0;
						state_reg <= CITD_SLOTS;
					end
				end
				CITD_SLOTS: begin
					// Branches inside delay slots are not chained
					if (insn_valid) begin
						if (slot_reg == citd_pkg::DELAY_SLOTS - 3'd1) begin
							redirect <= 1'b1;
							redirect_addr <= target_reg;
							state_reg <= CITD_IDLE;
						end else begin
							slot_reg <= slot_reg + 3'd1;
						end
					end
				end
				default: state_reg <= CITD_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** citd_dispatch_monitor.sv ***
// Concurrent checks on the dispatch decoder ports
`timescale 1ns/1ps
`default_nettype none
module citd_dispatch_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	// Issue
	input wire logic insn_valid,
	input wire logic [31:0] insn_word,
	input wire logic [4:0] cond_nonzero,
	// Results
	input wire logic commit,
	input wire logic pred_illegal,
	input wire logic mem_load,
	input wire logic mem_store,
	input wire logic mem_unit2,
	input wire logic branch_taken,
	input wire logic redirect
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================
	// Branch steps
	sequence s_taken;
		branch_taken && insn_valid;
	endsequence
	sequence s_slots;
		insn_valid [*4];
	endsequence
	// ==========================================
	// Properties
	a_bad_cond_drop: assert property (
		insn_valid && insn_word[31:29] > 3'd5 |=> pred_illegal && !commit)
		else $error("bad condition code not dropped");
	a_false_pred_nop: assert property (
		insn_valid && insn_word[31:28] == 4'h2 && !cond_nonzero[0]
		|=> !commit && !mem_load && !mem_store && !branch_taken)
		else $error("false predicate had an effect");
	a_true_pred_run: assert property (
		insn_valid && insn_word[31:23] == 9'h150 && cond_nonzero[4]
		|=> commit && mem_store && !mem_unit2)
		else $error("true predicate store not run");
	a_long_load_unit: assert property (
		insn_valid && insn_word[31:24] == 8'h07 |=> mem_load && mem_unit2)
		else $error("long load not on second unit");
	a_long_store_unit: assert property (
		insn_valid && insn_word[31:24] == 8'h09 |=> mem_store && mem_unit2)
		else $error("long store not on second unit");
	a_slot_count: assert property (s_taken ##1 s_slots |=> redirect)
		else $error("no redirect after five slots");
	a_no_early_jump: assert property (branch_taken |-> !redirect [*5])
		else $error("redirect inside delay slots");
	a_untaken_branch: assert property (
		insn_valid && insn_word[31:24] == 8'h21 && !cond_nonzero[0]
		|=> !branch_taken)
		else $error("branch taken on false condition");
	a_unmapped_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
		else $error("unmapped access without error");
endmodule
bind citd_dispatch citd_dispatch_monitor citd_dispatch_monitor_inst (.clk, .srst, .psel, .penable,
	.paddr, .pslverr, .insn_valid, .insn_word, .cond_nonzero, .commit, .pred_illegal, .mem_load,
	.mem_store, .mem_unit2, .branch_taken, .redirect);
`default_nettype wire

// *** citd_tb.sv ***
// Directed testbench for the dispatch decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, insn_valid = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, insn_word = 0, insn_pc = 0, src_data = 0;
	logic [3:0] pstrb = 4'hf;
	logic [15:0] irq_pin = 0;
	logic [4:0] cond_nonzero = 0;
	logic [31:0] prdata, ctrl_rdata, redirect_addr;
	logic pready, pslverr, irq, commit, pred_illegal, mem_load, mem_store, mem_unit2;
	logic branch_taken, redirect;
	int miscompares = 0, compares = 0;
	always #2.5 clk = ~clk;
	citd_dispatch citd_dispatch_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .irq_pin, .irq, .insn_valid, .insn_word, .insn_pc,
		.src_data, .cond_nonzero, .commit, .pred_illegal, .mem_load, .mem_store, .mem_unit2,
		.ctrl_rdata, .branch_taken, .redirect, .redirect_addr);
	// ==========================================
	// Helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		e = pslverr;
		r = prdata;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(0, a, 0, r, e);
		chk(r, x);
	endtask
	function automatic logic [31:0] mk(input logic [3:0] cz, input logic [3:0] op,
		input logic [23:0] lo);
		return {cz, op, lo};
	endfunction
	task automatic insn(input logic [31:0] w, input logic [31:0] s, input logic [4:0] cn);
		@(posedge clk);
		{insn_valid, insn_word, src_data, cond_nonzero} <= {1'b1, w, s, cn};
		@(posedge clk);
		insn_valid <= 0;
		#1;
	endtask
	task automatic br(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] x);
		@(posedge clk);
		{insn_valid, insn_word, insn_pc, src_data} <= {1'b1, w, pc, 32'h8000_0010};
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			insn_word <= 0;
			#1;
			if (i == 0) chk(branch_taken, 1);
			chk(redirect, 0);
		end
		@(posedge clk);
		insn_valid <= 0;
		#1;
		chk(redirect, 1);
		chk(redirect_addr, x);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		rd(citd_pkg::CSR_OFS, citd_pkg::CSR_RST);
		rd(citd_pkg::TABLE_OFS, citd_pkg::TABLE_RST);
		rd(citd_pkg::RETPTR_OFS, citd_pkg::RETPTR_RST);
		wr(citd_pkg::RETPTR_OFS, 32'hdead_beef);
		rd(citd_pkg::RETPTR_OFS, 32'hdead_beef);
		apb(0, 8'h20, 0, r, e);
		chk(e, 1);
		chk(r, 0);
		// One byte lane only; low ten bits never read back
		@(posedge clk) pstrb <= 4'h2;
		wr(citd_pkg::TABLE_OFS, 32'hffff_ffff);
		rd(citd_pkg::TABLE_OFS, 32'h0000_fc00);
		@(posedge clk) pstrb <= 4'hf;
	endtask
	task automatic t_irq();
		wr(citd_pkg::ENABLE_OFS, 32'h0000_0030);
		wr(citd_pkg::TABLE_OFS, 32'h0000_4000);
		wr(citd_pkg::CSR_OFS, 32'h0000_00f1);
		@(posedge clk) irq_pin <= 16'h0030;
		repeat (8) @(posedge clk);
		chk(irq, 1);
		rd(citd_pkg::TABLE_OFS, 32'h0000_4040);
		rd(citd_pkg::PEND_OFS, 32'h0000_0030);
		wr(citd_pkg::CLEAR_OFS, 32'h0000_0010);
		rd(citd_pkg::PEND_OFS, 32'h0000_0020);
		rd(citd_pkg::TABLE_OFS, 32'h0000_4050);
		wr(citd_pkg::CSR_OFS, 32'h0000_00f0);
		rd(citd_pkg::CSR_OFS, 32'h0000_00f0);
		chk(irq, 0);
		wr(citd_pkg::PEND_OFS, 32'h0000_0020);
		rd(citd_pkg::TABLE_OFS, 32'h0000_4000);
		rd(citd_pkg::CLEAR_OFS, 0);
	endtask
	task automatic t_pred();
		for (int c = 1; c < 8; c++) begin
			insn(mk(4'(c * 2), 4'h6, 0), 0, 5'h00);
			chk(commit, 0);
			chk(pred_illegal, c > 5);
			insn(mk(4'(c * 2), 4'h6, 0), 0, 5'h1f);
			chk(commit, c < 6);
			insn(mk(4'(c * 2 + 1), 4'h6, 0), 0, 5'h00);
			chk(commit, c < 6);
		end
		insn(mk(4'h8, 4'h4, 24'h3), 32'h1234_5678, 5'h17);
		rd(citd_pkg::RETPTR_OFS, 32'hdead_beef);
		insn(mk(4'h8, 4'h4, 24'h3), 32'h1234_5678, 5'h08);
		insn(mk(4'h0, 4'h5, 24'h3), 0, 5'h00);
		chk(ctrl_rdata, 32'h1234_5678);
		insn(mk(4'h2, 4'h1, 0), 0, 5'h00);
		chk(branch_taken, 0);
		insn(mk(4'ha, 4'h8, 0), 0, 5'h10);
		chk(mem_store, 1);
		chk(mem_unit2, 0);
	endtask
	task automatic t_mem();
		for (int i = 6; i < 10; i++) begin
			insn(mk(0, 4'(i), 0), 0, 0);
			chk(mem_unit2, i == 7 || i == 9);
			chk(mem_load, i < 8);
			chk(mem_store, i > 7);
		end
		insn(mk(0, 4'h6, 24'h80_0000), 0, 0);
		chk(mem_unit2, 1);
	endtask
	task automatic stop_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		srst <= 0;
		t_regs();
		t_irq();
		t_pred();
		t_mem();
		br(mk(0, 4'h1, 24'h1f_ffff), 32'h0000_1000, 32'h0000_0ffc);
		br(mk(0, 4'h1, 24'h0f_ffff), 32'h0000_0000, 32'h003f_fffc);
		br(mk(0, 4'h2, 0), 0, 32'h8000_0010);
		br(mk(0, 4'h3, 0), 0, 32'h1234_5678);
		stop_test();
	end
	initial begin
		#20000;
		miscompares++;
		stop_test();
	end
endmodule
`default_nettype wire
